/* File: rtl/clk_sys_pkg.sv */
// Constants, register map and carrier types of the system clock selector and prescaler.
package clk_sys_pkg;
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_SEL = 10'h000;
  localparam logic [9:0] IDX_PSC = 10'h001;
  localparam logic [9:0] IDX_OSC_EN = 10'h002;
  localparam logic [9:0] IDX_OSC_STAT = 10'h003;
  localparam logic [9:0] IDX_PLL = 10'h004;
  localparam logic [9:0] IDX_FMON = 10'h005;
  localparam logic [9:0] IDX_CAL_CTRL = 10'h006;
  localparam logic [9:0] IDX_CAL2M = 10'h007;
  localparam logic [9:0] IDX_CAL32M = 10'h008;
  localparam logic [9:0] IDX_COMP32M = 10'h009;
  localparam logic [2:0] SRC_2M = 3'h0;
  localparam logic [2:0] SRC_32M = 3'h1;
  localparam logic [2:0] SRC_32K = 3'h2;
  localparam logic [2:0] SRC_EXT = 3'h3;
  localparam logic [2:0] SRC_PLL = 3'h4;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [7:0] PSC_RST = 8'h00;
  localparam logic [7:0] OSC_EN_RST = 8'h01;
  localparam logic [4:0] ADIV_MAX_CODE = 5'h11;
  localparam int SW_OLD_CYC = 2;
  localparam int SW_NEW_CYC = 2;
  localparam int CAL_REF_DIV = 32;
  localparam logic [15:0] COMP_2M_RST = 16'h07a1;
  localparam logic [15:0] COMP_32M_RST = 16'h7a12;
  localparam int PRESC_W = 11;

  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_OLD = 3'b010,
    SW_NEW = 3'b100
  } sw_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic [4:0] div;
    logic [15:0] cnt;
    logic [6:0] val;
  } cal_t;
endpackage

/* File: rtl/system_clock_select_prescale.sv */
// System clock source selection, glitch-free prescaler, PLL interlocks, calibration, monitor.
//
// What this block does
// - Refuse switching to unready oscillators and disabling the current source.
// - Each oscillator has a software-readable ready flag.
// - First prescaler stage divides 1 to 512, giving the x4 clock.
// - Second and third stages divide by up to 4 combined.
// - Undivided later stages run all clocks at first-stage rate.
// - Derived clocks stay phase aligned, no glitches or intermediate rates.
// - New prescaler settings apply on a slowest-clock rising edge.
// - Source select and prescaler writes need the timed-write unlock.
// - PLL output equals reference times multiplier 1 to 31.
// - Four PLL references: 2MHz, 32MHz/4, crystal, external clock.
// - PLL configuration is frozen while the PLL is enabled.
// - PLL is usable only with a stable reference and lock.
// - PLL reference cannot be disabled by software while the PLL runs.
// - Each calibration loop selects its reference, divided by 32.
// - Compare values reset to ideal ratios; 32MHz compare is writable.
// - Calibration steps by one when error exceeds half a step.
// - Calibration halts in sleep, resumes; writable while disabled.
// - External failure while system clock: fall back, reset, flag, NMI.
// - External failure otherwise: disable it silently, no NMI.
// - Monitor stays enabled until reset and pauses in sleep.
// - Switch takes two old then two new cycles; old stays enabled.
// - Selector codes 0 to 4 name the five sources, rest reserved.
// - First-stage code 0 undivided, odd codes 1 to 17 divide 2 to 512.
// - Later-stage codes: 00=1,1; 01=1,2; 10=4,1; 11=2,2.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module system_clock_select_prescale
  import clk_sys_pkg::*;
#(
  parameter logic [15:0] CAL_HALF_STEP = 16'h0001,
  parameter logic [6:0] CAL_VAL_RST = 7'h40
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire apb_req_t i_apb,
  output apb_rsp_t o_apb,
  input wire logic i_ccp_unlock,
  input wire logic [3:0] i_osc_stable,
  input wire logic i_pll_locked,
  input wire logic i_sleep_osc_stop,
  input wire logic i_ext_fail,
  input wire logic [1:0] i_cal_ref_edge,
  input wire logic [1:0] i_cal_osc_edge,
  output logic [4:0] o_osc_enable,
  output logic [2:0] o_sys_clk_source,
  output logic o_sys_clk_switching,
  output logic o_periph_clk_x4_tick,
  output logic o_periph_clk_x2_tick,
  output logic o_cpu_clk_tick,
  output logic [4:0] o_pll_multiplier,
  output logic [1:0] o_pll_ref_sel,
  output logic [3:0] o_cal_ref_sel,
  output logic [6:0] o_cal_value_2m,
  output logic [6:0] o_cal_value_32m,
  output logic o_fail_monitor_en,
  output logic o_nmi
);

  typedef struct packed {
    logic [2:0] sel;
    logic [2:0] act;
    sw_state_t sw;
    logic swc;
    logic [6:0] psc;
    logic [4:0] ea;
    logic [1:0] ebc;
    logic [PRESC_W-1:0] cnt;
    logic t4;
    logic t2;
    logic tc;
    logic [4:0] osc_en;
    logic [4:0] pll_mul;
    logic [1:0] pll_src;
    logic fm_en;
    logic fm_flag;
    logic nmi;
    logic [1:0] cal_en;
    logic [3:0] cal_ref;
    cal_t [1:0] cal;
    logic [15:0] comp32;
    logic [31:0] prdata;
  } state_t;

  state_t r;
  state_t n;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic [3:0] a_shift(input logic [4:0] c);
    return (c == 5'h00) ? 4'h0 : (4'(c >> 1) + 4'h1);
  endfunction

  function automatic logic [3:0] b_shift(input logic [1:0] c);
    return (c == 2'h2) ? 4'h2 : ((c == 2'h3) ? 4'h1 : 4'h0);
  endfunction

  function automatic logic [PRESC_W-1:0] lo_mask(input logic [3:0] s);
    return PRESC_W'((12'h001 << s) - 12'h001);
  endfunction

  function automatic logic hit(input logic [PRESC_W-1:0] c, input logic [3:0] s);
    return (c & lo_mask(s)) == lo_mask(s);
  endfunction

  function automatic logic [1:0] pll_ref_bit(input logic [1:0] s);
    return (s == 2'h2) ? 2'h3 : s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Decode and ready flags.

  logic [9:0] idx;
  logic mapped;
  logic wr;
  logic [31:0] wd;
  logic [3:0] osc_rdy;
  logic [4:0] rdy;
  logic [4:0] keep;
  logic apply;
  logic fail;
  logic [3:0] sa;
  logic [3:0] sb;
  logic [3:0] sc;
  logic [15:0] cmp;
  logic [31:0] rd;

  assign idx = i_apb.paddr[ADDR_W-1:2];
  assign mapped = (idx <= IDX_COMP32M) && (i_apb.paddr[1:0] == 2'h0);
  assign wr = i_apb.psel & i_apb.penable & i_apb.pwrite & mapped;
  assign wd = i_apb.pwdata;
  assign osc_rdy = r.osc_en[3:0] & i_osc_stable;
  assign rdy = {r.osc_en[4] & i_pll_locked & osc_rdy[pll_ref_bit(r.pll_src)], osc_rdy};
  assign keep = (5'h01 << r.act) | (5'h01 << r.sel) |
                (r.osc_en[4] ? (5'h01 << pll_ref_bit(r.pll_src)) : 5'h00);
  assign fail = r.fm_en & ~i_sleep_osc_stop & i_ext_fail;

  always_comb begin
    rd = 32'h0000_0000;
    unique case (idx)
      IDX_SEL: rd = {29'h0, r.sel};
      IDX_PSC: rd = {25'h0, r.psc};
      IDX_OSC_EN: rd = {27'h0, r.osc_en};
      IDX_OSC_STAT: rd = {27'h0, rdy};
      IDX_PLL: rd = {24'h0, r.pll_src, 1'b0, r.pll_mul};
      IDX_FMON: rd = {30'h0, r.fm_flag, r.fm_en};
      IDX_CAL_CTRL: rd = {26'h0, r.cal_ref, r.cal_en};
      IDX_CAL2M: rd = {25'h0, r.cal[0].val};
      IDX_CAL32M: rd = {25'h0, r.cal[1].val};
      IDX_COMP32M: rd = {16'h0, r.comp32};
      default: rd = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    n = r;
    n.nmi = 1'b0;
    cmp = 16'h0000;
    if (i_apb.psel && !i_apb.penable) begin
      n.prdata = rd;
    end

    apply = r.tc & ({r.ea, r.ebc} != r.psc);
    if (apply) begin
      n.ea = r.psc[6:2];
      n.ebc = r.psc[1:0];
      n.cnt = '0;
    end else begin
      n.cnt = r.cnt + PRESC_W'(1);
    end
    sa = a_shift(n.ea);
    sb = sa + b_shift(n.ebc);
    sc = sb + {3'h0, n.ebc[0]};
    n.t4 = hit(n.cnt, sa);
    n.t2 = hit(n.cnt, sb);
    n.tc = hit(n.cnt, sc);

    if (wr && idx == IDX_PSC && i_ccp_unlock) begin
      if (wd[6:2] <= ADIV_MAX_CODE && (wd[6:2] == 5'h00 || wd[2])) begin
        n.psc = wd[6:0];
      end
    end

    unique case (r.sw)
      SW_IDLE: begin
        if (wr && idx == IDX_SEL && i_ccp_unlock && wd[2:0] <= SRC_PLL) begin
          if (rdy[wd[2:0]] && wd[2:0] != r.act) begin
            n.sel = wd[2:0];
            n.sw = SW_OLD;
            n.swc = 1'b0;
          end
        end
      end
      SW_OLD: begin
        n.swc = ~r.swc;
        if (r.swc == 1'(SW_OLD_CYC - 1)) begin
          n.act = r.sel;
          n.sw = SW_NEW;
          n.swc = 1'b0;
        end
      end
      SW_NEW: begin
        n.swc = ~r.swc;
        if (r.swc == 1'(SW_NEW_CYC - 1)) begin
          n.sw = SW_IDLE;
          n.swc = 1'b0;
        end
      end
    endcase

    if (wr && idx == IDX_OSC_EN) begin
      n.osc_en = wd[4:0] | keep;
    end

    if (wr && idx == IDX_PLL && i_ccp_unlock && !r.osc_en[4] && wd[4:0] != 5'h00) begin
      n.pll_mul = wd[4:0];
      n.pll_src = wd[7:6];
    end

    if (wr && idx == IDX_FMON) begin
      if (wd[0] && i_ccp_unlock) begin
        n.fm_en = 1'b1;
      end
      if (wd[1]) begin
        n.fm_flag = 1'b0;
      end
    end

    if (wr && idx == IDX_CAL_CTRL) begin
      n.cal_en = wd[1:0];
      n.cal_ref = wd[5:2];
    end
    if (wr && idx == IDX_COMP32M) begin
      n.comp32 = wd[15:0];
    end

    for (int k = 0; k < 2; k++) begin
      if (!r.cal_en[k]) begin
        n.cal[k].div = 5'h00;
        n.cal[k].cnt = 16'h0000;
        if (wr && idx == (k == 0 ? IDX_CAL2M : IDX_CAL32M)) begin
          n.cal[k].val = wd[6:0];
        end
      end else if (!i_sleep_osc_stop) begin
        if (i_cal_osc_edge[k] && r.cal[k].cnt != 16'hffff) begin
          n.cal[k].cnt = r.cal[k].cnt + 16'h0001;
        end
        if (i_cal_ref_edge[k]) begin
          n.cal[k].div = r.cal[k].div + 5'h01;
          if (r.cal[k].div == 5'(CAL_REF_DIV - 1)) begin
            cmp = (k == 0) ? COMP_2M_RST : r.comp32;
            n.cal[k].cnt = 16'h0000;
            if ({1'b0, r.cal[k].cnt} > {1'b0, cmp} + {1'b0, CAL_HALF_STEP}) begin
              if (r.cal[k].val != 7'h00) begin
                n.cal[k].val = r.cal[k].val - 7'h01;
              end
            end else if ({1'b0, r.cal[k].cnt} + {1'b0, CAL_HALF_STEP} < {1'b0, cmp}) begin
              if (r.cal[k].val != 7'h7f) begin
                n.cal[k].val = r.cal[k].val + 7'h01;
              end
            end
          end
        end
      end
    end

    if (fail) begin
      if (r.act == SRC_EXT || r.sel == SRC_EXT) begin
        n.sel = SEL_RST[2:0];
        n.act = SEL_RST[2:0];
        n.sw = SW_IDLE;
        n.swc = 1'b0;
        n.osc_en = OSC_EN_RST[4:0];
        n.fm_flag = 1'b1;
        n.nmi = 1'b1;
      end else begin
        n.osc_en[3] = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      r <= '0;
      r.sel <= SEL_RST[2:0];
      r.act <= SEL_RST[2:0];
      r.sw <= SW_IDLE;
      r.psc <= PSC_RST[6:0];
      r.ea <= PSC_RST[6:2];
      r.ebc <= PSC_RST[1:0];
      r.t4 <= 1'b1;
      r.t2 <= 1'b1;
      r.tc <= 1'b1;
      r.osc_en <= OSC_EN_RST[4:0];
      r.pll_mul <= 5'h01;
      r.cal[0].val <= CAL_VAL_RST;
      r.cal[1].val <= CAL_VAL_RST;
      r.comp32 <= COMP_32M_RST;
    end else begin
      r <= n;
    end
  end

  assign o_apb.pready = 1'b1;
  assign o_apb.prdata = r.prdata;
  assign o_apb.pslverr = i_apb.psel & i_apb.penable & ~mapped;
  assign o_osc_enable = r.osc_en;
  assign o_sys_clk_source = r.act;
  assign o_sys_clk_switching = (r.sw != SW_IDLE);
  assign o_periph_clk_x4_tick = r.t4;
  assign o_periph_clk_x2_tick = r.t2;
  assign o_cpu_clk_tick = r.tc;
  assign o_pll_multiplier = r.pll_mul;
  assign o_pll_ref_sel = r.pll_src;
  assign o_cal_ref_sel = r.cal_ref;
  assign o_cal_value_2m = r.cal[0].val;
  assign o_cal_value_32m = r.cal[1].val;
  assign o_fail_monitor_en = r.fm_en;
  assign o_nmi = r.nmi;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  property p_src_on;
    $past(!fail) |-> r.osc_en[r.act];
  endproperty
  a_src_on: assert property (p_src_on) else $error("current source disabled");

  property p_nodiv;
    (r.ea == 5'h00 && r.ebc == 2'h0) |-> (r.t4 && r.t2 && r.tc);
  endproperty
  a_nodiv: assert property (p_nodiv) else $error("undivided clocks not equal");

  property p_aligned;
    r.tc |-> (r.t2 && r.t4);
  endproperty
  a_aligned: assert property (p_aligned) else $error("cpu tick not aligned");

  property p_apply_edge;
    $changed({r.ea, r.ebc}) |-> $past(r.tc);
  endproperty
  a_apply_edge: assert property (p_apply_edge) else $error("prescaler applied off edge");

  property p_locked_sel;
    (wr && idx == IDX_SEL && !i_ccp_unlock) |=> $stable(r.sel);
  endproperty
  a_locked_sel: assert property (p_locked_sel) else $error("unprotected select write");

  property p_pll_frozen;
    (r.osc_en[4] && $past(r.osc_en[4])) |-> $stable({r.pll_mul, r.pll_src});
  endproperty
  a_pll_frozen: assert property (p_pll_frozen) else $error("pll config changed");

  property p_pll_ready;
    ($rose(r.sw == SW_OLD) && r.sel == SRC_PLL) |-> $past(rdy[4]);
  endproperty
  a_pll_ready: assert property (p_pll_ready) else $error("pll selected unready");

  property p_fail_nmi;
    (fail && r.act == SRC_EXT) |=> (r.act == SRC_2M && r.nmi && r.fm_flag);
  endproperty
  a_fail_nmi: assert property (p_fail_nmi) else $error("no fallback on failure");

  property p_fm_sticky;
    r.fm_en |=> r.fm_en;
  endproperty
  a_fm_sticky: assert property (p_fm_sticky) else $error("monitor disabled");

  property p_switch;
    (r.sw == SW_IDLE ##1 r.sw == SW_OLD) |-> (r.sw == SW_OLD && !fail) ##1
      (r.sw == SW_NEW && !fail)[*2] ##1 (r.sw == SW_IDLE) or ##[0:4] fail;
  endproperty
  a_switch: assert property (p_switch) else $error("switch timing wrong");

  property p_reset_dflt;
    $past(i_reset) |-> (r.act == SRC_2M && r.ea == 5'h00 && !r.fm_en);
  endproperty
  a_reset_dflt: assert property (p_reset_dflt) else $error("bad reset state");

  c_pll_switch: cover property (r.sw == SW_NEW && r.act == SRC_PLL);
  c_fail_nmi: cover property (r.nmi);
  c_apply: cover property (apply && r.psc[6:2] != 5'h00);
  c_cal_step: cover property ($changed(r.cal[1].val) && r.cal_en[1]);

endmodule

/* File: test/tb.sv */
// Self-checking testbench of the system clock selector and prescaler.
`timescale 1ns/1ps
module tb;
  import clk_sys_pkg::*;
  localparam int LIMIT = 20000;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_ccp_unlock = 1'b0;
  logic [3:0] i_osc_stable = 4'hf;
  logic i_pll_locked = 1'b1;
  logic i_ext_fail = 1'b0;
  logic [1:0] cref = 2'h0;
  logic slp = 1'b0;
  logic [3:0] cal_ref;
  logic [6:0] cal32m;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic [4:0] osc_en, pll_mul;
  logic [2:0] src;
  logic sw, x4, x2, cpu, fmon, nmi;
  logic [1:0] pll_ref;
  logic [6:0] cal2m;
  logic [31:0] q;
  logic e;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;

  system_clock_select_prescale dut (.i_clk(i_clk), .i_reset(i_reset), .i_apb(req), .o_apb(rsp),
    .i_ccp_unlock(i_ccp_unlock), .i_osc_stable(i_osc_stable), .i_pll_locked(i_pll_locked),
    .i_sleep_osc_stop(slp), .i_ext_fail(i_ext_fail), .i_cal_ref_edge(cref),
    .i_cal_osc_edge(2'h0), .o_osc_enable(osc_en), .o_sys_clk_source(src),
    .o_sys_clk_switching(sw), .o_periph_clk_x4_tick(x4), .o_periph_clk_x2_tick(x2),
    .o_cpu_clk_tick(cpu), .o_pll_multiplier(pll_mul), .o_pll_ref_sel(pll_ref),
    .o_cal_ref_sel(cal_ref), .o_cal_value_2m(cal2m), .o_cal_value_32m(cal32m),
    .o_fail_monitor_en(fmon),
    .o_nmi(nmi));

  initial begin
    forever #20 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  function automatic logic [11:0] ad(input logic [9:0] i);
    return {i, 2'b00};
  endfunction

  // One APB transfer; the request stands until pready is seen high at a rising edge.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic u);
    @(posedge i_clk);
    i_ccp_unlock <= u;
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge i_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    i_ccp_unlock <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    apb(ad(i), 1'b1, d, 1'b0);
  endtask

  task automatic pw(input logic [9:0] i, input logic [31:0] d);
    apb(ad(i), 1'b1, d, 1'b1);
    @(negedge i_clk);
  endtask

  task automatic rd(input logic [9:0] i);
    apb(ad(i), 1'b0, 32'h0, 1'b0);
  endtask

  task automatic sel_sw(input logic [2:0] c, input int exp_n);
    pw(IDX_SEL, {29'h0, c});
    n = 0;
    repeat (12) begin
      if (sw === 1'b1) n++;
      @(negedge i_clk);
    end
    chk(n, exp_n);
  endtask

  function automatic logic tk(input int w);
    return (w == 0) ? x4 : (w == 1) ? x2 : cpu;
  endfunction

  task automatic gap(input int w, input int x);
    int g;
    int k;
    k = 0;
    while (tk(w) !== 1'b1 && k < 2000) begin
      @(negedge i_clk);
      k++;
    end
    @(negedge i_clk);
    g = 1;
    while (tk(w) !== 1'b1 && g < 2000) begin
      @(negedge i_clk);
      g++;
    end
    chk(g, x);
  endtask

  // Thirty-two one-cycle reference pulses for loop 0, with the sleep input set to s.
  task automatic ref_burst(input logic s);
    @(posedge i_clk);
    slp <= s;
    repeat (32) begin
      @(posedge i_clk);
      cref <= 2'h1;
      @(posedge i_clk);
      cref <= 2'h0;
    end
    @(negedge i_clk);
  endtask

  task automatic fail_pulse();
    @(posedge i_clk);
    i_ext_fail <= 1'b1;
    @(posedge i_clk);
    i_ext_fail <= 1'b0;
    n = 0;
    repeat (8) begin
      @(negedge i_clk);
      if (nmi === 1'b1) n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(IDX_SEL);
    chk(q, 32'h0);
    rd(IDX_PSC);
    chk(q, 32'h0);
    chk({src, osc_en, fmon}, {SRC_2M, 5'h01, 1'b0});
    rd(10'h00a);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_select();
    int c;
    sel_sw(SRC_32M, 0);
    wr(IDX_OSC_EN, 32'h0f);
    i_osc_stable <= 4'hd;
    sel_sw(SRC_32M, 0);
    i_osc_stable <= 4'hf;
    wr(IDX_SEL, 32'h1);
    @(negedge i_clk);
    chk(src, SRC_2M);
    sel_sw(3'h5, 0);
    pw(IDX_PLL, 32'h01);
    wr(IDX_OSC_EN, 32'h1f);
    for (c = 1; c <= 5; c++) begin
      sel_sw(c % 5, SW_OLD_CYC + SW_NEW_CYC);
      chk(src, c % 5);
      rd(IDX_SEL);
      chk(q, c % 5);
      if (c == 1) begin
        wr(IDX_OSC_EN, 32'h1d);
        @(negedge i_clk);
        chk(osc_en[1], 1'b1);
      end
    end
    $display("test select done");
  endtask

  task automatic t_pll();
    int r;
    int m;
    wr(IDX_OSC_EN, 32'h0f);
    for (r = 0; r < 4; r++) begin
      m = (r == 3) ? 31 : r + 1;
      pw(IDX_PLL, (r << 6) | m);
      chk({pll_ref, pll_mul}, {r[1:0], m[4:0]});
    end
    pw(IDX_PLL, 32'h45);
    i_pll_locked <= 1'b0;
    wr(IDX_OSC_EN, 32'h1f);
    rd(IDX_OSC_STAT);
    chk(q[4], 1'b0);
    sel_sw(SRC_PLL, 0);
    i_pll_locked <= 1'b1;
    rd(IDX_OSC_STAT);
    chk(q[4], 1'b1);
    pw(IDX_PLL, 32'h47);
    chk(pll_mul, 5'h05);
    wr(IDX_OSC_EN, 32'h1d);
    @(negedge i_clk);
    chk(osc_en[1], 1'b1);
    wr(IDX_OSC_EN, 32'h0f);
    pw(IDX_PLL, 32'h47);
    chk(pll_mul, 5'h07);
    $display("test pll done");
  endtask

  task automatic t_prescale();
    int cd[5] = '{0, 3, 0, 0, 17};
    int lt[5] = '{0, 3, 1, 2, 0};
    int bd[4] = '{1, 1, 4, 2};
    int cdv[4] = '{1, 2, 1, 2};
    int i;
    int a;
    for (i = 0; i < 5; i++) begin
      pw(IDX_PSC, (cd[i] << 2) | lt[i]);
      repeat (40) @(negedge i_clk);
      a = (cd[i] == 0) ? 1 : 1 << ((cd[i] + 1) / 2);
      gap(0, a);
      gap(1, a * bd[lt[i]]);
      gap(2, a * bd[lt[i]] * cdv[lt[i]]);
    end
    pw(IDX_PSC, 32'h55);
    rd(IDX_PSC);
    chk(q, 32'h44);
    pw(IDX_PSC, 32'h0);
    $display("test prescale done");
  endtask

  task automatic t_fmon();
    pw(IDX_FMON, 32'h1);
    sel_sw(SRC_EXT, SW_OLD_CYC + SW_NEW_CYC);
    fail_pulse();
    chk(n, 1);
    chk({src, osc_en}, {SRC_2M, 5'h01});
    rd(IDX_FMON);
    chk(q[1], 1'b1);
    rd(IDX_SEL);
    chk(q, 32'h0);
    wr(IDX_FMON, 32'h2);
    wr(IDX_FMON, 32'h0);
    @(negedge i_clk);
    chk(fmon, 1'b1);
    wr(IDX_OSC_EN, 32'h09);
    fail_pulse();
    chk(n, 0);
    chk({src, osc_en}, {SRC_2M, 5'h01});
    $display("test monitor done");
  endtask

  task automatic t_cal();
    wr(IDX_CAL2M, 32'h22);
    @(negedge i_clk);
    chk(cal2m, 7'h22);
    rd(IDX_COMP32M);
    chk(q, {16'h0, COMP_32M_RST});
    wr(IDX_COMP32M, 32'h1234);
    rd(IDX_COMP32M);
    chk(q, 32'h1234);
    wr(IDX_CAL32M, 32'h33);
    @(negedge i_clk);
    chk(cal32m, 7'h33);
    wr(IDX_CAL_CTRL, 32'h25);
    @(negedge i_clk);
    chk(cal_ref, 4'h9);
    wr(IDX_CAL2M, 32'h11);
    @(negedge i_clk);
    chk(cal2m, 7'h22);
    ref_burst(1'b0);
    chk(cal2m, 7'h23);
    ref_burst(1'b1);
    chk(cal2m, 7'h23);
    $display("test calibration done");
  endtask

  initial begin
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    t_reset();
    t_select();
    t_pll();
    t_prescale();
    t_fmon();
    t_cal();
    close_out();
  end
endmodule
